// >>> design/dpp_map.vh
/*
  register offsets, field positions, reset values and widths of the
  dual parallel port block.
  assumes it is included by bare name from each design file.
*/
`ifndef DPP_MAP_VH
`define DPP_MAP_VH

// ==========================================================
// widths
`define DPP_PORT_W        8
`define DPP_SEL_W         4

// ==========================================================
// register select codes
`define DPP_REG_B_DATA    4'h0
`define DPP_REG_A_DATA    4'h1
`define DPP_REG_B_DIR     4'h2
`define DPP_REG_A_DIR     4'h3
`define DPP_REG_AUX       4'hb
`define DPP_REG_PERIPH    4'hc
`define DPP_REG_A_QUIET   4'hf

// ==========================================================
// field positions
`define DPP_AUX_LATCH_A   0
`define DPP_AUX_LATCH_B   1
`define DPP_PER_EDGE_A    0
`define DPP_PER_EDGE_B    4

// ==========================================================
// reset values
`define DPP_RST_BYTE      8'h00
`define DPP_RST_DIR       8'h00
`define DPP_RST_LATCH     8'h00
`define DPP_RST_AUX       8'h00
`define DPP_RST_PERIPH    8'h00

// ==========================================================
// timing counts
`define DPP_SYNC_STAGES   2

`endif

// >>> design/dpp_sync.v
/*
  two flip-flop synchroniser for a bundle of independent levels.
  assumes each bit is a slow level from outside the core_clk domain;
  bits are not coherent with one another.
*/
`default_nettype none
`include "dpp_map.vh"

module dpp_sync #(
  parameter WIDTH = 8
) (
  // clock and reset
  input  wire             core_clk,
  input  wire             rst,
  // asynchronous levels in, synchronised levels out
  input  wire [WIDTH-1:0] async_in,
  output reg  [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] stage_one;

  // ==========================================================
  // two stages; only the second stage reads the first
  always @(posedge core_clk) begin
    if (rst) begin
      stage_one <= {WIDTH{1'b0}};
      sync_out  <= {WIDTH{1'b0}};
    end else begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end

endmodule
`default_nettype wire

// >>> design/dpp_in_capture.v
/*
  input register of one port: transparent to the synchronised lines,
  or holding the levels caught at an active strobe transition.
  assumes pins and strobe are already synchronised to core_clk.
*/
`default_nettype none
`include "dpp_map.vh"

module dpp_in_capture (
  // clock and reset
  input  wire                  core_clk,
  input  wire                  rst,
  // synchronised line levels and strobe
  input  wire [`DPP_PORT_W-1:0] pins_sync,
  input  wire                  strobe_sync,
  // control
  input  wire                  edge_rising,
  input  wire                  latch_en,
  input  wire                  read_release,
  // result
  output wire [`DPP_PORT_W-1:0] in_view,
  output reg                   held
);

  localparam ARM_LEN = `DPP_SYNC_STAGES + 1;

  reg                   strobe_prev;
  reg [ARM_LEN-1:0]     arm_pipe;
  wire                  armed;
  reg [`DPP_PORT_W-1:0] snap;
  wire                  rise;
  wire                  fall;
  wire                  active_edge;

  // edge detection stays blind until the synchroniser holds real levels,
  // so a strobe idling high gives no false edge after reset
  assign armed       = arm_pipe[ARM_LEN-1];

  // edge detection on the synchronised strobe
  assign rise        = strobe_sync & ~strobe_prev;
  assign fall        = ~strobe_sync & strobe_prev;
  assign active_edge = armed & (edge_rising ? rise : fall);

  // ==========================================================
  // capture and release; a new edge wins over a release read
  always @(posedge core_clk) begin
    if (rst) begin
      strobe_prev <= 1'b0;
      arm_pipe    <= {ARM_LEN{1'b0}};
      snap        <= `DPP_RST_BYTE;
      held        <= 1'b0;
    end else begin
      strobe_prev <= strobe_sync;
      arm_pipe    <= {arm_pipe[ARM_LEN-2:0], 1'b1};  // no edge from the reset value
      if (!latch_en) begin
        held <= 1'b0;
      end else if (active_edge) begin
        snap <= pins_sync;
        held <= 1'b1;
      end else if (read_release) begin
        held <= 1'b0;
      end
    end
  end

  // held snapshot or live lines
  assign in_view = held ? snap : pins_sync;

endmodule
`default_nettype wire

// >>> design/dpp_port.v
/*
  dual 8-bit parallel port: direction masks, output latches, input
  registers with optional strobe latching, reached by register select.
  assumes a synchronous processor bus on core_clk: cpu_select is held
  high for exactly the cycle of an access, with reg_select, cpu_write
  and cpu_data_in valid in that cycle. port lines and strobes are
  asynchronous and are synchronised here.
  a read answers one cycle after its access edge: cpu_data_oe is high
  for that one cycle and cpu_data_out keeps the value until the next
  read. a write lands at its access edge and shows on the pins from
  that same edge. reset leaves every line an input with all latches,
  masks and control registers cleared.
*/
`default_nettype none
`include "dpp_map.vh"

module dpp_port (
  // clock and reset
  input  wire                   core_clk,
  input  wire                   rst,
  // processor register access
  input  wire                   cpu_select,
  input  wire                   cpu_write,
  input  wire [`DPP_SEL_W-1:0]  reg_select,
  input  wire [`DPP_PORT_W-1:0] cpu_data_in,
  output reg  [`DPP_PORT_W-1:0] cpu_data_out,
  output reg                    cpu_data_oe,
  // port a lines
  input  wire [`DPP_PORT_W-1:0] port_a_lines_in,
  output wire [`DPP_PORT_W-1:0] port_a_lines_out,
  output wire [`DPP_PORT_W-1:0] port_a_lines_oe,
  // port b lines
  input  wire [`DPP_PORT_W-1:0] port_b_lines_in,
  output wire [`DPP_PORT_W-1:0] port_b_lines_out,
  output wire [`DPP_PORT_W-1:0] port_b_lines_oe,
  // strobe inputs
  input  wire                   strobe_a,
  input  wire                   strobe_b
);

  // ==========================================================
  // register decode

  // port a data is reached through both the plain and quiet codes;
  // the quiet code has no handshake here, so both act alike
  function is_port_a_data;
    input [`DPP_SEL_W-1:0] sel;
    begin
      is_port_a_data = (sel == `DPP_REG_A_DATA) || (sel == `DPP_REG_A_QUIET);
    end
  endfunction

  // ==========================================================
  // state

  // output latches, direction masks and control registers
  reg  [`DPP_PORT_W-1:0] out_latch_a;
  reg  [`DPP_PORT_W-1:0] out_latch_b;
  reg  [`DPP_PORT_W-1:0] dir_mask_a;
  reg  [`DPP_PORT_W-1:0] dir_mask_b;
  reg  [`DPP_PORT_W-1:0] aux_control;
  reg  [`DPP_PORT_W-1:0] periph_control;

  // synchronised levels, input registers and read views
  wire [`DPP_PORT_W-1:0] pins_a_sync;
  wire [`DPP_PORT_W-1:0] pins_b_sync;
  wire [1:0]             strobe_sync;
  wire [`DPP_PORT_W-1:0] in_view_a;
  wire [`DPP_PORT_W-1:0] in_view_b;
  wire [`DPP_PORT_W-1:0] read_a;
  wire [`DPP_PORT_W-1:0] read_b;

  // access qualifiers and control selects
  wire                   bus_write;
  wire                   bus_read;
  wire                   read_a_data;
  wire                   read_b_data;
  wire                   latch_en_a;
  wire                   latch_en_b;
  wire                   edge_rising_a;
  wire                   edge_rising_b;

  // read answer before its register
  reg  [`DPP_PORT_W-1:0] next_read_data;

  // ==========================================================
  // access qualifiers
  assign bus_write   = cpu_select & cpu_write;
  assign bus_read    = cpu_select & ~cpu_write;

  // data register reads, which release held input values
  assign read_a_data = bus_read & is_port_a_data(reg_select);
  assign read_b_data = bus_read & (reg_select == `DPP_REG_B_DATA);

  // latching and edge selects from the control registers;
  // other control bits are stored and read back but drive nothing
  assign latch_en_a    = aux_control[`DPP_AUX_LATCH_A];
  assign latch_en_b    = aux_control[`DPP_AUX_LATCH_B];
  assign edge_rising_a = periph_control[`DPP_PER_EDGE_A];
  assign edge_rising_b = periph_control[`DPP_PER_EDGE_B];

  // ==========================================================
  // synchronisers for lines and strobes

  // bits of one port are synchronised independently, so a byte
  // that changes near a clock edge may read as a mix for one cycle

  // port a line levels
  dpp_sync #(
    .WIDTH (`DPP_PORT_W)
  ) u_sync_a (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (port_a_lines_in),
    .sync_out (pins_a_sync)
  );

  // port b line levels
  dpp_sync #(
    .WIDTH (`DPP_PORT_W)
  ) u_sync_b (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (port_b_lines_in),
    .sync_out (pins_b_sync)
  );

  // both strobes, bit 0 is a, bit 1 is b
  dpp_sync #(
    .WIDTH (2)
  ) u_sync_strobe (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({strobe_b, strobe_a}),
    .sync_out (strobe_sync)
  );

  // ==========================================================
  // input registers

  // port a input register; either data code releases the hold;
  // a snapshot stands until it is read, a new active edge replaces it, or latching is switched off
  dpp_in_capture u_cap_a (
    .core_clk     (core_clk),
    .rst          (rst),
    .pins_sync    (pins_a_sync),
    .strobe_sync  (strobe_sync[0]),
    .edge_rising  (edge_rising_a),
    .latch_en     (latch_en_a),
    .read_release (read_a_data),
    .in_view      (in_view_a),
    .held         ()
  );

  // port b input register; its data code releases the hold, and an
  // active edge in the same cycle as that read wins
  dpp_in_capture u_cap_b (
    .core_clk     (core_clk),
    .rst          (rst),
    .pins_sync    (pins_b_sync),
    .strobe_sync  (strobe_sync[1]),
    .edge_rising  (edge_rising_b),
    .latch_en     (latch_en_b),
    .read_release (read_b_data),
    .in_view      (in_view_b),
    .held         ()
  );

  // ==========================================================
  // per-line read views; port a sees loading on its driven lines,
  // port b reads back what was written whatever the load
  genvar i;
  generate
    for (i = 0; i < `DPP_PORT_W; i = i + 1) begin : g_line
      // a output lines show the live pin, inputs the input register
      assign read_a[i] = dir_mask_a[i] ? pins_a_sync[i] : in_view_a[i];
      // b output lines show the stored latch bit
      assign read_b[i] = dir_mask_b[i] ? out_latch_b[i] : in_view_b[i];
    end
  endgenerate

  // ==========================================================
  // register writes
  always @(posedge core_clk) begin
    if (rst) begin
      out_latch_a    <= `DPP_RST_LATCH;
      out_latch_b    <= `DPP_RST_LATCH;
      dir_mask_a     <= `DPP_RST_DIR;
      dir_mask_b     <= `DPP_RST_DIR;
      aux_control    <= `DPP_RST_AUX;
      periph_control <= `DPP_RST_PERIPH;
    end else if (bus_write) begin
      // a latch write to an input line is kept until the line turns output
      case (reg_select)
        // port b output latch
        `DPP_REG_B_DATA: begin
          out_latch_b <= cpu_data_in;
        end
        // port a output latch, plain and quiet codes
        `DPP_REG_A_DATA, `DPP_REG_A_QUIET: begin
          out_latch_a <= cpu_data_in;
        end
        // port b direction mask
        `DPP_REG_B_DIR: begin
          dir_mask_b <= cpu_data_in;
        end
        // port a direction mask
        `DPP_REG_A_DIR: begin
          dir_mask_a <= cpu_data_in;
        end
        // latching enables, all bits stored
        `DPP_REG_AUX: begin
          aux_control <= cpu_data_in;
        end
        // strobe edge selects, all bits stored
        `DPP_REG_PERIPH: begin
          periph_control <= cpu_data_in;
        end
        default: begin
          // unmapped codes ignore writes
        end
      endcase
    end
  end

  // ==========================================================
  // read data selection
  always @* begin
    case (reg_select)
      // port b data view
      `DPP_REG_B_DATA: begin
        next_read_data = read_b;
      end
      // port a data view, plain and quiet codes
      `DPP_REG_A_DATA, `DPP_REG_A_QUIET: begin
        next_read_data = read_a;
      end
      // direction masks read back as written
      `DPP_REG_B_DIR: begin
        next_read_data = dir_mask_b;
      end
      `DPP_REG_A_DIR: begin
        next_read_data = dir_mask_a;
      end
      // control registers read back every stored bit
      `DPP_REG_AUX: begin
        next_read_data = aux_control;
      end
      `DPP_REG_PERIPH: begin
        next_read_data = periph_control;
      end
      default: begin
        next_read_data = `DPP_RST_BYTE;  // unmapped reads as zero
      end
    endcase
  end

  // registered read answer, driven for one cycle after the read;
  // cpu_data_out is left alone on writes and idle cycles
  always @(posedge core_clk) begin
    if (rst) begin
      cpu_data_out <= `DPP_RST_BYTE;
      cpu_data_oe  <= 1'b0;
    end else begin
      cpu_data_oe <= bus_read;
      if (bus_read) begin
        cpu_data_out <= next_read_data;
      end
    end
  end

  // ==========================================================
  // pin drive straight from the latch and mask flip-flops; a line
  // that is an input keeps its latch bit ready for when it turns output

  // port a drive
  assign port_a_lines_out = out_latch_a;
  assign port_a_lines_oe  = dir_mask_a;

  // port b drive
  assign port_b_lines_out = out_latch_b;
  assign port_b_lines_oe  = dir_mask_b;

endmodule
`default_nettype wire

// >>> verification/dpp_port_checker.sv
/*
  bus and pin relations of dpp_port, checked at its ports.
  assumes it is bound to each dpp_port instance.
*/
`default_nettype none
module dpp_port_checker (
  // clock and reset
  input wire logic       core_clk,
  input wire logic       rst,
  // processor access
  input wire logic       cpu_select,
  input wire logic       cpu_write,
  input wire logic [3:0] reg_select,
  input wire logic [7:0] cpu_data_in,
  input wire logic [7:0] cpu_data_out,
  input wire logic       cpu_data_oe,
  // port lines
  input wire logic [7:0] port_a_lines_out,
  input wire logic [7:0] port_a_lines_oe,
  input wire logic [7:0] port_b_lines_out,
  input wire logic [7:0] port_b_lines_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  logic rd;
  logic wr;
  // ==========================================================
  // access decode
  assign rd = cpu_select & ~cpu_write;
  assign wr = cpu_select & cpu_write;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ==========================================================
  // read answer and hold
  rd_answer_a: assert property (rd |=> cpu_data_oe)
    else $error("no data enable after read");
  idle_quiet_a: assert property (!rd |=> !cpu_data_oe)
    else $error("data enable without read");
  data_hold_a: assert property (!rd |=> $stable(cpu_data_out))
    else $error("read data moved without read");
  gap_zero_a: assert property (rd && reg_select == 4'h4 |=> cpu_data_out == 8'h00)
    else $error("unmapped read not zero");
  b_out_read_a: assert property (rd && reg_select == 4'h0 |=>
    ((cpu_data_out ^ port_b_lines_out) & port_b_lines_oe) == 8'h00)
    else $error("port b output bit not latch");
  // ==========================================================
  // writes reaching the pins
  dir_b_a: assert property (wr && reg_select == 4'h2 |=> port_b_lines_oe == $past(cpu_data_in))
    else $error("direction b write lost");
  dir_a_a: assert property (wr && reg_select == 4'h3 |=> port_a_lines_oe == $past(cpu_data_in))
    else $error("direction a write lost");
  latch_b_a: assert property (wr && reg_select == 4'h0 |=> port_b_lines_out == $past(cpu_data_in))
    else $error("latch b write lost");
  latch_a_a: assert property (wr && (reg_select == 4'h1 || reg_select == 4'hf) |=>
    port_a_lines_out == $past(cpu_data_in))
    else $error("latch a write lost");
  latch_keep_a: assert property (!wr |=> $stable(port_a_lines_out) && $stable(port_b_lines_out))
    else $error("latch moved without write");
endmodule

bind dpp_port dpp_port_checker i_chk (
  .core_clk(core_clk), .rst(rst), .cpu_select(cpu_select), .cpu_write(cpu_write),
  .reg_select(reg_select), .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out),
  .cpu_data_oe(cpu_data_oe), .port_a_lines_out(port_a_lines_out), .port_a_lines_oe(port_a_lines_oe),
  .port_b_lines_out(port_b_lines_out), .port_b_lines_oe(port_b_lines_oe));
`default_nettype wire

// >>> verification/dpp_periph.sv
/*
  peripheral devices on both port buses.
  assumes the bench sets what they drive and which lines are heavily loaded.
*/
`default_nettype none
module dpp_periph (
  // design side of the lines
  input  wire logic [7:0] a_out,
  input  wire logic [7:0] a_oe,
  input  wire logic [7:0] b_out,
  input  wire logic [7:0] b_oe,
  // peripheral drive and load
  input  wire logic [7:0] a_ext,
  input  wire logic [7:0] b_ext,
  input  wire logic [7:0] load,
  // levels seen by the design
  output logic      [7:0] a_in,
  output logic      [7:0] b_in
);
  timeunit 1ns;
  timeprecision 1ns;
  // driven lines win but loaded ones sag low; others carry the peripheral
  assign a_in = (a_oe & a_out & ~load) | (~a_oe & a_ext);
  assign b_in = (b_oe & b_out & ~load) | (~b_oe & b_ext);
endmodule
`default_nettype wire

// >>> verification/tb_dual_parallel_port.sv
/*
  self-checking bench of dpp_port with the peripheral model.
  assumes the checker is bound to the design.
*/
`default_nettype none
module tb_dual_parallel_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk = 1'b0, rst = 1'b1, cpu_select = 1'b0, cpu_write = 1'b0;
  logic        strobe_a = 1'b1, strobe_b = 1'b1;
  logic [3:0]  reg_select = 4'h0, sel;
  logic [7:0]  cpu_data_in = 8'h00, a_ext = 8'h00, b_ext = 8'h00, load = 8'h00;
  logic [7:0]  rdat, da, db, la, lb, v1, v2;
  logic [31:0] seed = 32'h0000_005e;
  wire  [7:0]  cpu_data_out, a_out, a_oe, b_out, b_oe, a_in, b_in;
  wire         cpu_data_oe;
  int          fails = 0, num_checks = 0, cyc = 0, p, e;

  // ==========================================================
  // clock, design and peripherals
  always #10 core_clk = ~core_clk;
  dpp_port i_dut (.core_clk(core_clk), .rst(rst), .cpu_select(cpu_select), .cpu_write(cpu_write),
    .reg_select(reg_select), .cpu_data_in(cpu_data_in), .cpu_data_out(cpu_data_out),
    .cpu_data_oe(cpu_data_oe), .port_a_lines_in(a_in), .port_a_lines_out(a_out),
    .port_a_lines_oe(a_oe), .port_b_lines_in(b_in), .port_b_lines_out(b_out),
    .port_b_lines_oe(b_oe), .strobe_a(strobe_a), .strobe_b(strobe_b));
  dpp_periph i_periph (.a_out(a_out), .a_oe(a_oe), .b_out(b_out), .b_oe(b_oe),
    .a_ext(a_ext), .b_ext(b_ext), .load(load), .a_in(a_in), .b_in(b_in));

  // ==========================================================
  // helpers
  function automatic logic [7:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  // read value: latch or pin for outputs, input register otherwise
  function automatic logic [7:0] mix(input logic [7:0] d, o, i);
    return (d & o) | (~d & i);
  endfunction
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] x, g);
    num_checks++;
    if (g !== x) begin
      $display("wrong value %s expected %h seen %h", n, x, g);
      fails++;
    end
  endtask
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    @(negedge core_clk);
    {cpu_select, cpu_write, reg_select, cpu_data_in} = {2'b11, s, d};
    @(negedge core_clk);
    {cpu_select, cpu_write} = 2'b00;
  endtask
  // data is taken in the cycle after the access, while enable stands
  task automatic rchk(input logic [3:0] s, input logic [7:0] x, input string n);
    @(negedge core_clk);
    {cpu_select, cpu_write, reg_select} = {2'b10, s};
    @(negedge core_clk);
    cpu_select = 1'b0;
    rdat = (cpu_data_oe === 1'b1) ? cpu_data_out : 8'hxx;
    chk(n, x, rdat);
  endtask
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 4000) begin
      fails++;
      print_verdict();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("oe a", 8'h00, a_oe);
    rchk(4'h2, 8'h00, "dir b");
    // random directions, latches and peripheral levels
    repeat (24) begin
      {da, db, la, lb} = {xs(), xs(), xs(), xs()};
      {a_ext, b_ext} = {xs(), xs()};
      wr(4'h1, la);
      wr(4'h3, da);
      wr(4'h0, lb);
      wr(4'h2, db);
      repeat (3) @(negedge core_clk);
      chk("pins a", la, a_out);
      chk("oe b", db, b_oe);
      chk("pins b", lb, b_out);
      chk("dir pins a", da, a_oe);
      rchk(4'h1, mix(da, la, a_ext), "data a");
      rchk(4'hf, mix(da, la, a_ext), "quiet a");
      rchk(4'h0, mix(db, lb, b_ext), "data b");
      rchk(4'h3, da, "dir a");
    end
    // heavy load on driven lines
    for (int r = 0; r < 4; r++) wr(r[3:0], 8'hff);
    load = 8'h0f;
    repeat (3) @(negedge core_clk);
    rchk(4'h1, 8'hf0, "loaded a");
    rchk(4'h0, 8'hff, "loaded b");
    load = 8'h00;
    wr(4'h3, 8'h00);
    wr(4'h2, 8'h00);
    rchk(4'h4, 8'h00, "unmapped");
    // strobe latching for each port and edge
    for (p = 0; p < 2; p++) for (e = 0; e < 2; e++) begin
      sel = p ? 4'h0 : 4'h1;
      wr(4'hb, p ? 8'h02 : 8'h01);
      wr(4'hc, e ? 8'h11 : 8'h00);
      rchk(4'hb, p ? 8'h02 : 8'h01, "aux");
      rchk(4'hc, e ? 8'h11 : 8'h00, "periph");
      {strobe_a, strobe_b} = {2{e == 0}};
      v1 = xs();
      v2 = ~v1;
      {a_ext, b_ext} = {v1, v1};
      repeat (4) @(negedge core_clk);
      {strobe_a, strobe_b} = {2{e != 0}};
      repeat (4) @(negedge core_clk);
      {a_ext, b_ext} = {v2, v2};
      repeat (3) @(negedge core_clk);
      rchk(p ? 4'h1 : 4'h0, v2, "unlatched");
      rchk(sel, v1, "held");
      rchk(sel, v2, "released");
    end
    // second reset in mid-run clears latches, masks and controls
    @(negedge core_clk);
    rst = 1'b1;
    repeat (3) @(negedge core_clk);
    rst = 1'b0;
    repeat (3) @(negedge core_clk);
    chk("reset pins b", 8'h00, b_out);
    chk("reset oe a", 8'h00, a_oe);
    rchk(4'hb, 8'h00, "reset aux");
    print_verdict();
  end
endmodule
`default_nettype wire
